//--- rtl/temp_alarm_pkg.sv
// Shared constants of the temperature alarm signalling logic.
// Assumes one system clock and an 8-bit register port from the serial engine.
package temp_alarm_pkg;

   // Register offsets, as the serial command byte selects them.
   localparam logic [7:0] ALARM_FLAGS_ADDR    = 8'h02;
   localparam logic [7:0] DEV_CONFIG_ADDR     = 8'h09;
   localparam logic [7:0] REMOTE_CRIT_ADDR    = 8'h19;
   localparam logic [7:0] LOCAL_CRIT_ADDR     = 8'h20;
   localparam logic [7:0] CRIT_HYST_ADDR      = 8'h21;
   localparam logic [7:0] ALARM_MODE_ADDR     = 8'hBF;

   // Values after power-on reset.
   localparam logic [7:0] DEV_CONFIG_RST      = 8'h00;
   localparam logic [7:0] ALARM_MODE_RST      = 8'h00;
   localparam logic [7:0] CRIT_SETPOINT_RST   = 8'h55;
   localparam logic [7:0] CRIT_HYST_RST       = 8'h0A;
   localparam logic [6:0] FLAGS_RST           = 7'h00;
   localparam logic [7:0] UNMAPPED_RDATA      = 8'h00;
   localparam logic [7:0] ARA_IDLE_BYTE       = 8'hFF;

   // Field positions.
   localparam int unsigned CFG_MASK_BIT       = 7;
   localparam int unsigned MODE_CMP_BIT       = 0;
   localparam int unsigned FLAG_BUSY_BIT      = 7;
   localparam int unsigned FLAG_LHIGH_BIT     = 6;
   localparam int unsigned FLAG_LLOW_BIT      = 5;
   localparam int unsigned FLAG_RHIGH_BIT     = 4;
   localparam int unsigned FLAG_RLOW_BIT      = 3;
   localparam int unsigned FLAG_OPEN_BIT      = 2;
   localparam int unsigned FLAG_REM_CRIT_BIT  = 1;
   localparam int unsigned FLAG_LOC_CRIT_BIT  = 0;

   // Flags that may pull the alarm line: all but busy and diode open.
   localparam logic [6:0] ALARM_FLAG_SET      = 7'h7B;

   // Channel numbering.
   localparam int unsigned CH_LOCAL           = 0;
   localparam int unsigned CH_REMOTE          = 1;

   // Alert response sequencer states.
   typedef enum logic [1:0]
   {
      ARA_IDLE = 2'b01,
      ARA_SEND = 2'b10
   } ara_state_t;

endpackage

//--- rtl/temp_limit_check.sv
// Limit comparison of one channel's conversion result.
// Assumes signed two's complement readings and setpoints in whole degrees.
`timescale 1ns/1ps
module temp_limit_check
(
   input  wire logic [7:0] temp,
   input  wire logic [7:0] high_limit,
   input  wire logic [7:0] low_limit,
   input  wire logic [7:0] crit_limit,
   input  wire logic [7:0] hyst,
   input  wire logic       crit_active,
   output logic            over_high,
   output logic            under_low,
   output logic            over_crit,
   output logic            crit_next
);

   logic signed [8:0] temp_s;
   logic signed [8:0] release_s;

   // Widen by one bit so that the setpoint minus a hysteresis of up to 128 cannot wrap.
   assign temp_s    = {temp[7], temp};
   assign release_s = $signed({crit_limit[7], crit_limit}) - $signed({1'b0, hyst});

   // Plain window comparisons on the new reading.
   assign over_high = $signed(temp) > $signed(high_limit);
   assign under_low = $signed(temp) < $signed(low_limit);
   assign over_crit = $signed(temp) > $signed(crit_limit);

   // Critical output sets above the setpoint and drops only below the hysteresis floor.
   // hysteresis release point
   assign crit_next = over_crit | (crit_active & ~(temp_s < release_s));

endmodule

//--- rtl/temp_alarm_output_logic.sv
// Alarm and critical-temperature output logic of a local/remote sensor.
// Assumes conversion results and register accesses arrive on the system clock
// from the converter and the serial engine; the pins are open drain outside.
//
// Functional notes
// - Comparator mode releases alarm when condition clears.
// - Only mode bit high selects comparator.
// - Mode bit low selects interrupt; default.
// - Interrupt alarm holds until status read or sent address.
// - Interrupt-mode status read sets mask if alarms set.
// - Mask set keeps alarm output released.
// - Latched flags cleared only by status read.
// - Clear-on-read only in interrupt mode.
// - Service read clears, releases, masks together.
// - Masked new over-limit result stays silent.
// - Alerting device answers alert response read.
// - Lowest address wins; loser keeps alarm.
// - Sent address releases alarm, sets mask.
// - Alert response only in interrupt mode.
// - Reset clears mask and mode bit.
// - Response byte is address then one.
// - No alerting device gives all ones.
// - Over critical drives critical low, flags.
// - Flags and critical updated per conversion.
// - Critical releases below setpoint minus hysteresis.
// - Unmasked alarm flag drives alarm low.
// - Diode open flag never raises alarm.
`timescale 1ns/1ps
module temp_alarm_output_logic
   import temp_alarm_pkg::*;
(
   input  wire logic       CLK_SYS,
   input  wire logic       RST_B,
   input  wire logic       REG_WR,
   input  wire logic       REG_RD,
   input  wire logic [7:0] REG_ADDR,
   input  wire logic [7:0] REG_WDATA,
   output logic      [7:0] REG_RDATA,
   input  wire logic       CONV_DONE,
   input  wire logic       CONV_REMOTE,
   input  wire logic [7:0] CONV_TEMP,
   input  wire logic       CONV_OPEN,
   input  wire logic       CONV_BUSY,
   input  wire logic [7:0] LOCAL_HIGH,
   input  wire logic [7:0] LOCAL_LOW,
   input  wire logic [7:0] REMOTE_HIGH,
   input  wire logic [7:0] REMOTE_LOW,
   input  wire logic [6:0] DEV_ADDR,
   input  wire logic       ARA_REQ,
   input  wire logic       ARA_DONE,
   input  wire logic       ARA_LOST,
   output logic            ARA_ACTIVE,
   output logic      [7:0] ARA_BYTE,
   input  wire logic       ALARM_OUT_N_I,
   output logic            ALARM_OUT_N_O,
   output logic            ALARM_OUT_N_OE_N,
   input  wire logic       CRITICAL_OUT_N_I,
   output logic            CRITICAL_OUT_N_O,
   output logic            CRITICAL_OUT_N_OE_N
);

   logic       rst_meta_q;
   logic       rst_sync_q;
   logic       rst_n;

   logic [7:0] dev_config_q;
   logic [7:0] dev_config_d;
   logic [7:0] alarm_mode_reg_q;
   logic [7:0] local_crit_setpoint_q;
   logic [7:0] remote_crit_setpoint_q;
   logic [7:0] crit_hysteresis_q;
   logic [6:0] flags_q;
   logic [6:0] flags_d;
   logic [6:0] conv_set;
   logic [6:0] conv_upd;
   logic [1:0] crit_active_q;
   logic [1:0] crit_active_d;
   logic       alarm_drive_q;
   logic       crit_drive_q;
   logic [7:0] rdata_q;
   logic [7:0] ara_byte_q;
   ara_state_t ara_state_q;
   ara_state_t ara_state_d;

   logic       cmp_mode;
   logic       mask_q;
   logic       status_read;
   logic       service_read;
   logic       ara_win;
   logic       alarm_pending;

   // Per-channel comparison inputs and results, index 0 local, 1 remote.
   logic [7:0] ch_high [2];
   logic [7:0] ch_low  [2];
   logic [7:0] ch_crit [2];
   logic [1:0] ch_over_high;
   logic [1:0] ch_under_low;
   logic [1:0] ch_over_crit;
   logic [1:0] ch_crit_next;

   // Reset is asserted at once and released through two flops.
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   // Mode and mask decode.
   // comparator needs bit
   assign cmp_mode = alarm_mode_reg_q[MODE_CMP_BIT];
   assign mask_q   = dev_config_q[CFG_MASK_BIT];

   // A status read clears flags only in interrupt mode.
   // interrupt mode only
   assign status_read  = REG_RD && (REG_ADDR == ALARM_FLAGS_ADDR);
   assign service_read = status_read && !cmp_mode;

   // Flags that are allowed to raise the alarm, diode open and busy excluded.
   // open bit excluded
   assign alarm_pending = |(flags_q & ALARM_FLAG_SET);

   // Route the setpoints to the two comparator instances.
   assign ch_high[CH_LOCAL]  = LOCAL_HIGH;
   assign ch_high[CH_REMOTE] = REMOTE_HIGH;
   assign ch_low[CH_LOCAL]   = LOCAL_LOW;
   assign ch_low[CH_REMOTE]  = REMOTE_LOW;
   assign ch_crit[CH_LOCAL]  = local_crit_setpoint_q;
   assign ch_crit[CH_REMOTE] = remote_crit_setpoint_q;

   // One comparator per channel; both see the same reading, only the
   // channel named by the conversion uses its answer.
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++)
      begin : g_chan
         temp_limit_check u_check
         (
            .temp        (CONV_TEMP),
            .high_limit  (ch_high[ch]),
            .low_limit   (ch_low[ch]),
            .crit_limit  (ch_crit[ch]),
            .hyst        (crit_hysteresis_q),
            .crit_active (crit_active_q[ch]),
            .over_high   (ch_over_high[ch]),
            .under_low   (ch_under_low[ch]),
            .over_crit   (ch_over_crit[ch]),
            .crit_next   (ch_crit_next[ch])
         );
         // Critical state moves only when this channel finishes a conversion.
         // per conversion update
         assign crit_active_d[ch] = (CONV_DONE && (CONV_REMOTE == (ch == CH_REMOTE)))
                                    ? ch_crit_next[ch] : crit_active_q[ch];
      end
   endgenerate

   // Flags produced by the conversion that completes in this cycle.
   // critical sets flag
   always_comb
   begin
      conv_set = 7'h00;
      conv_upd = 7'h00;
      if (CONV_DONE)
      begin
         if (CONV_REMOTE)
         begin
            conv_upd[FLAG_RHIGH_BIT] = 1'b1;
            conv_upd[FLAG_RLOW_BIT]  = 1'b1;
            conv_upd[FLAG_OPEN_BIT]  = 1'b1;
            conv_upd[FLAG_REM_CRIT_BIT] = 1'b1;
            conv_set[FLAG_RHIGH_BIT] = ch_over_high[CH_REMOTE];
            conv_set[FLAG_RLOW_BIT]  = ch_under_low[CH_REMOTE];
            conv_set[FLAG_OPEN_BIT]  = CONV_OPEN;
            conv_set[FLAG_REM_CRIT_BIT] = ch_over_crit[CH_REMOTE];
         end
         else
         begin
            conv_upd[FLAG_LHIGH_BIT] = 1'b1;
            conv_upd[FLAG_LLOW_BIT]  = 1'b1;
            conv_upd[FLAG_LOC_CRIT_BIT] = 1'b1;
            conv_set[FLAG_LHIGH_BIT] = ch_over_high[CH_LOCAL];
            conv_set[FLAG_LLOW_BIT]  = ch_under_low[CH_LOCAL];
            conv_set[FLAG_LOC_CRIT_BIT] = ch_over_crit[CH_LOCAL];
         end
      end
   end

   // Interrupt mode latches flags until a status read; a set arriving in the
   // same cycle as that read survives it. Comparator mode tracks each reading.
   always_comb
   begin
      flags_d = flags_q;
      if (cmp_mode)
      begin
         flags_d = (flags_q & ~conv_upd) | conv_set;
      end
      else
      begin
         flags_d = (service_read ? FLAGS_RST : flags_q) | conv_set;
      end
   end

   // Configuration next value; hardware setting the mask wins over a host write.
   always_comb
   begin
      dev_config_d = dev_config_q;
      if (REG_WR && (REG_ADDR == DEV_CONFIG_ADDR))
      begin
         dev_config_d = REG_WDATA;
      end
      if (service_read && alarm_pending)
      begin
         dev_config_d[CFG_MASK_BIT] = 1'b1;
      end
      if (ara_win)
      begin
         dev_config_d[CFG_MASK_BIT] = 1'b1;
      end
   end

   // Flag register.
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flags_q <= FLAGS_RST;
      end
      else
      begin
         flags_q <= flags_d;
      end
   end

   // Critical channel state.
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         crit_active_q <= 2'b00;
      end
      else
      begin
         crit_active_q <= crit_active_d;
      end
   end

   // Software-written registers.
   // reset clears mask, mode
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dev_config_q           <= DEV_CONFIG_RST;
         alarm_mode_reg_q       <= ALARM_MODE_RST;
         local_crit_setpoint_q  <= CRIT_SETPOINT_RST;
         remote_crit_setpoint_q <= CRIT_SETPOINT_RST;
         crit_hysteresis_q      <= CRIT_HYST_RST;
      end
      else
      begin
         dev_config_q <= dev_config_d;
         if (REG_WR)
         begin
            case (REG_ADDR)
               ALARM_MODE_ADDR:  alarm_mode_reg_q       <= {7'h00, REG_WDATA[MODE_CMP_BIT]};
               LOCAL_CRIT_ADDR:  local_crit_setpoint_q  <= REG_WDATA;
               REMOTE_CRIT_ADDR: remote_crit_setpoint_q <= REG_WDATA;
               CRIT_HYST_ADDR:   crit_hysteresis_q      <= REG_WDATA;
               default:          ;
            endcase
         end
      end
   end

   // Read data is registered and shows the flags as they were before the clear.
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_q <= UNMAPPED_RDATA;
      end
      else if (REG_RD)
      begin
         case (REG_ADDR)
            ALARM_FLAGS_ADDR: rdata_q <= {CONV_BUSY, flags_q};
            DEV_CONFIG_ADDR:  rdata_q <= dev_config_q;
            ALARM_MODE_ADDR:  rdata_q <= alarm_mode_reg_q;
            LOCAL_CRIT_ADDR:  rdata_q <= local_crit_setpoint_q;
            REMOTE_CRIT_ADDR: rdata_q <= remote_crit_setpoint_q;
            CRIT_HYST_ADDR:   rdata_q <= crit_hysteresis_q;
            default:          rdata_q <= UNMAPPED_RDATA;
         endcase
      end
   end
   assign REG_RDATA = rdata_q;

   // Alert response sequencer. Only an interrupt-mode device that is pulling
   // the line takes part; losing arbitration leaves the alarm untouched so the
   // host's next response read finds this device again.
   always_comb
   begin
      ara_state_d = ara_state_q;
      ara_win     = 1'b0;
      case (ara_state_q)
         ARA_IDLE:
         begin
            if (ARA_REQ && !cmp_mode && alarm_drive_q)
            begin
               ara_state_d = ARA_SEND;
            end
         end
         ARA_SEND:
         begin
            if (ARA_DONE)
            begin
               ara_win     = 1'b1;
               ara_state_d = ARA_IDLE;
            end
            else if (ARA_LOST)
            begin
               ara_state_d = ARA_IDLE;
            end
         end
         default:
         begin
            ara_state_d = ARA_IDLE;
         end
      endcase
   end

   // Sequencer state.
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ara_state_q <= ARA_IDLE;
      end
      else
      begin
         ara_state_q <= ara_state_d;
      end
   end

   // Response byte; all ones while not answering, as an undriven line reads.
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ara_byte_q <= ARA_IDLE_BYTE;
      end
      else if (ara_state_d == ARA_SEND)
      begin
         ara_byte_q <= {DEV_ADDR, 1'b1};
      end
      else
      begin
         ara_byte_q <= ARA_IDLE_BYTE;
      end
   end
   assign ARA_BYTE   = ara_byte_q;
   assign ARA_ACTIVE = (ara_state_q == ARA_SEND);

   // Alarm drive follows the next flags and mask, so a service read or a won
   // response releases the line in the same edge that clears or masks.
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         alarm_drive_q <= 1'b0;
      end
      else
      begin
         alarm_drive_q <= !dev_config_d[CFG_MASK_BIT] && |(flags_d & ALARM_FLAG_SET);
      end
   end

   // Critical line is low while either channel is latched critical and not yet below its release point.
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         crit_drive_q <= 1'b0;
      end
      else
      begin
         crit_drive_q <= |crit_active_d;
      end
   end

   // Open-drain pins: data is always low, the enable decides.
   // open-drain enables
   assign ALARM_OUT_N_O       = 1'b0;
   assign ALARM_OUT_N_OE_N    = !alarm_drive_q;
   assign CRITICAL_OUT_N_O    = 1'b0;
   assign CRITICAL_OUT_N_OE_N = !crit_drive_q;

endmodule

//--- verif/temp_alarm_asserts.sv
// Checker of the alarm output logic, bound to its top module.
// Assumes the mode bit changes only through the register port.
`timescale 1ns/1ps
module temp_alarm_asserts
   import temp_alarm_pkg::*;
(
   input wire logic       CLK_SYS,
   input wire logic       RST_B,
   input wire logic       REG_WR,
   input wire logic       REG_RD,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic       CONV_DONE,
   input wire logic [6:0] DEV_ADDR,
   input wire logic       ARA_DONE,
   input wire logic       ARA_LOST,
   input wire logic       ARA_REQ,
   input wire logic       ARA_ACTIVE,
   input wire logic [7:0] ARA_BYTE,
   input wire logic       ALARM_OUT_N_O,
   input wire logic       ALARM_OUT_N_OE_N,
   input wire logic       CRITICAL_OUT_N_O
);
   logic mode_q;
   logic stat_rd;

   // Shadow of the mode bit, so refusals in comparator mode can be told apart.
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         mode_q <= 1'b0;
      else if (REG_WR && REG_ADDR == ALARM_MODE_ADDR)
         mode_q <= REG_WDATA[0];
   end

   // A conversion in the same cycle could raise a fresh flag, so it is excluded.
   assign stat_rd = REG_RD && REG_ADDR == ALARM_FLAGS_ADDR && !mode_q && !CONV_DONE;

   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);

   // Each relation but a_ara_byte, a_ara_idle and a_open_drain ties an output to the request that caused it.
   property p_read_release;
      stat_rd |=> ALARM_OUT_N_OE_N;
   endproperty
   a_read_release: assert property (p_read_release) else $error("alarm held after read");
   property p_mask_hold;
      stat_rd && !ALARM_OUT_N_OE_N |=> ALARM_OUT_N_OE_N ##1 (ALARM_OUT_N_OE_N || $past(REG_WR));
   endproperty
   a_mask_hold: assert property (p_mask_hold) else $error("alarm while masked");
   property p_ara_byte;
      ARA_ACTIVE |-> ARA_BYTE == {DEV_ADDR, 1'b1};
   endproperty
   a_ara_byte: assert property (p_ara_byte) else $error("bad response byte");
   property p_ara_idle;
      !ARA_ACTIVE |-> ARA_BYTE == ARA_IDLE_BYTE;
   endproperty
   a_ara_idle: assert property (p_ara_idle) else $error("idle byte not ones");
   property p_ara_req;
      ARA_REQ && !ARA_ACTIVE && !ALARM_OUT_N_OE_N |=> ARA_ACTIVE == !$past(mode_q);
   endproperty
   a_ara_req: assert property (p_ara_req) else $error("response start wrong");
   property p_ara_done;
      ARA_ACTIVE && ARA_DONE |=> !ARA_ACTIVE && ALARM_OUT_N_OE_N;
   endproperty
   a_ara_done: assert property (p_ara_done) else $error("alarm kept after win");
   property p_ara_lost;
      ARA_ACTIVE && ARA_LOST && !ARA_DONE && !REG_WR && !REG_RD |=> !ARA_ACTIVE && !ALARM_OUT_N_OE_N;
   endproperty
   a_ara_lost: assert property (p_ara_lost) else $error("loser dropped alarm");
   property p_open_drain;
      !ALARM_OUT_N_O && !CRITICAL_OUT_N_O;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("pin driven high");

   // Main scenarios that the bench should reach.
   c_win: cover property (ARA_ACTIVE && ARA_DONE);
   c_lose: cover property (ARA_ACTIVE && ARA_LOST);
   c_service: cover property (stat_rd && !ALARM_OUT_N_OE_N);
endmodule

bind temp_alarm_output_logic temp_alarm_asserts chk
(
   .CLK_SYS(CLK_SYS),
   .RST_B(RST_B),
   .REG_WR(REG_WR),
   .REG_RD(REG_RD),
   .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA),
   .CONV_DONE(CONV_DONE),
   .DEV_ADDR(DEV_ADDR),
   .ARA_DONE(ARA_DONE),
   .ARA_LOST(ARA_LOST),
   .ARA_REQ(ARA_REQ),
   .ARA_ACTIVE(ARA_ACTIVE),
   .ARA_BYTE(ARA_BYTE),
   .ALARM_OUT_N_O(ALARM_OUT_N_O),
   .ALARM_OUT_N_OE_N(ALARM_OUT_N_OE_N),
   .CRITICAL_OUT_N_O(CRITICAL_OUT_N_O)
);

//--- verif/alert_host_model.sv
// Host side of the alert line, issuing alert response reads.
// Assumes a pull-up on the alarm line and calls from the bench.
`timescale 1ns/1ps
module alert_host_model
(
   input  wire logic       clk,
   input  wire logic       alarm_o,
   input  wire logic       alarm_oe_n,
   input  wire logic       ara_active,
   input  wire logic [7:0] ara_byte,
   output logic            ara_req,
   output logic            ara_done,
   output logic            ara_lost,
   output logic            alarm_wire
);
   assign alarm_wire = alarm_oe_n ? 1'b1 : alarm_o;

   // The model starts idle.
   initial
   begin
      ara_req = 1'b0;
      ara_done = 1'b0;
      ara_lost = 1'b0;
   end

   task automatic ara_read(input logic lose, input int slow, output logic [7:0] seen);
      int n;
      @(posedge clk);
      ara_req <= 1'b1;
      @(posedge clk);
      ara_req <= 1'b0;
      #1;
      n = 0;
      while (ara_active !== 1'b1 && n < 2)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      // Nobody answering leaves the data line at its pulled-up ones.
      seen = ara_byte;
      if (ara_active === 1'b1)
      begin
         repeat (slow) @(posedge clk);
         seen = ara_byte;
         @(posedge clk);
         ara_lost <= lose;
         ara_done <= !lose;
         @(posedge clk);
         ara_lost <= 1'b0;
         ara_done <= 1'b0;
         #1;
      end
   endtask
endmodule

//--- verif/temp_alarm_output_logic_tb.sv
// Self-checking bench of the alarm output logic.
// Assumes the host model stands on the alert line; both pins are pulled up.
`timescale 1ns/1ps
module temp_alarm_output_logic_tb
   import temp_alarm_pkg::*;
;
   logic       CLK_SYS, RST_B, REG_WR, REG_RD, CONV_DONE, CONV_REMOTE, CONV_OPEN, CONV_BUSY;
   logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, CONV_TEMP, ARA_BYTE, d;
   logic [6:0] DEV_ADDR;
   logic       ARA_REQ, ARA_DONE, ARA_LOST, ARA_ACTIVE, alarm_wire, crit_wire;
   logic       ALARM_OUT_N_O, ALARM_OUT_N_OE_N, CRITICAL_OUT_N_O, CRITICAL_OUT_N_OE_N;
   int         err_total, checks;

   // Free-running system clock.
   initial
   begin
      CLK_SYS = 1'b0;
      forever #20 CLK_SYS = ~CLK_SYS;
   end
   assign crit_wire = CRITICAL_OUT_N_OE_N ? 1'b1 : CRITICAL_OUT_N_O;

   // Setpoints stay fixed: high 46h and low 00h on both channels.
   temp_alarm_output_logic uut
   (
      .CLK_SYS(CLK_SYS), .RST_B(RST_B), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
      .CONV_DONE(CONV_DONE), .CONV_REMOTE(CONV_REMOTE), .CONV_TEMP(CONV_TEMP),
      .CONV_OPEN(CONV_OPEN), .CONV_BUSY(CONV_BUSY), .LOCAL_HIGH(8'h46), .LOCAL_LOW(8'h00),
      .REMOTE_HIGH(8'h46), .REMOTE_LOW(8'h00), .DEV_ADDR(DEV_ADDR), .ARA_REQ(ARA_REQ),
      .ARA_DONE(ARA_DONE), .ARA_LOST(ARA_LOST), .ARA_ACTIVE(ARA_ACTIVE), .ARA_BYTE(ARA_BYTE),
      .ALARM_OUT_N_I(alarm_wire), .ALARM_OUT_N_O(ALARM_OUT_N_O), .ALARM_OUT_N_OE_N(ALARM_OUT_N_OE_N),
      .CRITICAL_OUT_N_I(crit_wire), .CRITICAL_OUT_N_O(CRITICAL_OUT_N_O),
      .CRITICAL_OUT_N_OE_N(CRITICAL_OUT_N_OE_N)
   );
   alert_host_model host
   (
      .clk(CLK_SYS), .alarm_o(ALARM_OUT_N_O), .alarm_oe_n(ALARM_OUT_N_OE_N), .ara_active(ARA_ACTIVE),
      .ara_byte(ARA_BYTE), .ara_req(ARA_REQ), .ara_done(ARA_DONE), .ara_lost(ARA_LOST),
      .alarm_wire(alarm_wire)
   );

   // Shared compare, bus and conversion tasks; the bus and conversion ones start on a rising edge.
   task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("ERROR %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic pin(input string n, input logic e, input logic g);
      cmp(n, {7'h0, e}, {7'h0, g});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge CLK_SYS);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= v;
      @(posedge CLK_SYS);
      REG_WR <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
      @(posedge CLK_SYS);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge CLK_SYS);
      REG_RD <= 1'b0;
      #1;
      cmp(n, e, REG_RDATA);
   endtask
   task automatic conv(input logic rem, input logic [7:0] t, input logic op);
      @(posedge CLK_SYS);
      CONV_DONE <= 1'b1;
      CONV_REMOTE <= rem;
      CONV_TEMP <= t;
      CONV_OPEN <= op;
      @(posedge CLK_SYS);
      CONV_DONE <= 1'b0;
      #1;
   endtask

   task automatic t_reset();
      rd(DEV_CONFIG_ADDR, 8'h00, "config");
      rd(ALARM_MODE_ADDR, 8'h00, "mode");
      rd(8'h33, UNMAPPED_RDATA, "unmapped");
      pin("alarm idle", 1'b1, alarm_wire);
   endtask
   task automatic t_intr();
      conv(1'b1, 8'h50, 1'b0);
      pin("alarm set", 1'b0, alarm_wire);
      conv(1'b1, 8'h20, 1'b0);
      pin("alarm held", 1'b0, alarm_wire);
      rd(ALARM_FLAGS_ADDR, 8'h10, "flags");
      pin("alarm serviced", 1'b1, alarm_wire);
      rd(DEV_CONFIG_ADDR, 8'h80, "mask");
      conv(1'b1, 8'h50, 1'b0);
      pin("alarm masked", 1'b1, alarm_wire);
      wr(DEV_CONFIG_ADDR, 8'h00);
      pin("alarm again", 1'b0, alarm_wire);
      rd(ALARM_FLAGS_ADDR, 8'h10, "flags again");
      wr(DEV_CONFIG_ADDR, 8'h00);
   endtask
   task automatic t_open();
      conv(1'b1, 8'h20, 1'b1);
      pin("open quiet", 1'b1, alarm_wire);
      @(posedge CLK_SYS);
      CONV_BUSY <= 1'b1;
      rd(ALARM_FLAGS_ADDR, 8'h84, "open flags");
      @(posedge CLK_SYS);
      CONV_BUSY <= 1'b0;
      rd(DEV_CONFIG_ADDR, 8'h00, "no mask");
   endtask
   task automatic critical_out_n();
      conv(1'b1, 8'h60, 1'b0);
      pin("crit set", 1'b0, crit_wire);
      conv(1'b1, 8'h50, 1'b0);
      pin("crit hyst", 1'b0, crit_wire);
      conv(1'b1, 8'h40, 1'b0);
      pin("crit off", 1'b1, crit_wire);
      rd(ALARM_FLAGS_ADDR, 8'h12, "crit kept");
      conv(1'b0, 8'h60, 1'b0);
      pin("local crit", 1'b0, crit_wire);
      conv(1'b0, 8'h20, 1'b0);
      pin("local off", 1'b1, crit_wire);
      rd(ALARM_FLAGS_ADDR, 8'h41, "local flags");
      wr(DEV_CONFIG_ADDR, 8'h00);
   endtask
   task automatic t_cmp();
      wr(ALARM_MODE_ADDR, 8'hFF);
      rd(ALARM_MODE_ADDR, 8'h01, "mode set");
      conv(1'b1, 8'h50, 1'b0);
      pin("cmp alarm", 1'b0, alarm_wire);
      rd(ALARM_FLAGS_ADDR, 8'h10, "cmp flags");
      rd(ALARM_FLAGS_ADDR, 8'h10, "cmp kept");
      host.ara_read(1'b0, 0, d);
      cmp("cmp response", ARA_IDLE_BYTE, d);
      conv(1'b1, 8'h20, 1'b0);
      pin("cmp release", 1'b1, alarm_wire);
      conv(1'b0, 8'hF0, 1'b0);
      pin("cmp low", 1'b0, alarm_wire);
      conv(1'b0, 8'h20, 1'b0);
      pin("cmp low off", 1'b1, alarm_wire);
      wr(ALARM_MODE_ADDR, 8'h00);
   endtask
   task automatic t_ara();
      conv(1'b1, 8'h50, 1'b0);
      host.ara_read(1'b1, 0, d);
      cmp("lost byte", {DEV_ADDR, 1'b1}, d);
      pin("loser held", 1'b0, alarm_wire);
      host.ara_read(1'b0, 2, d);
      cmp("won byte", {DEV_ADDR, 1'b1}, d);
      pin("winner free", 1'b1, alarm_wire);
      rd(DEV_CONFIG_ADDR, 8'h80, "won mask");
      rd(ALARM_FLAGS_ADDR, 8'h10, "won flags");
      wr(DEV_CONFIG_ADDR, 8'h00);
      host.ara_read(1'b0, 0, d);
      cmp("no alert", ARA_IDLE_BYTE, d);
   endtask

   task automatic results();
      if (err_total == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Reset for two cycles, then run every scenario.
   initial
   begin
      err_total = 0;
      checks = 0;
      RST_B = 1'b0;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      REG_ADDR = 8'h00;
      REG_WDATA = 8'h00;
      CONV_DONE = 1'b0;
      CONV_REMOTE = 1'b0;
      CONV_TEMP = 8'h00;
      CONV_OPEN = 1'b0;
      CONV_BUSY = 1'b0;
      DEV_ADDR = 7'h2B;
      repeat (2) @(posedge CLK_SYS);
      RST_B <= 1'b1;
      repeat (3) @(posedge CLK_SYS);
      t_reset();
      t_intr();
      t_open();
      critical_out_n();
      t_cmp();
      t_ara();
      results();
   end

   // The scenarios need about a hundred cycles; this bound cuts a hang.
   initial
   begin
      repeat (3000) @(posedge CLK_SYS);
      err_total++;
      results();
   end
endmodule
